// ==== include/dma_ptr_pkg.sv ====
package dma_ptr_pkg;
  // register byte offsets within the block window
  localparam logic [15:0] TX_PTR_OFF     = 16'h9008;
  localparam logic [15:0] RX_PTR_OFF     = 16'h900c;
  localparam logic [15:0] RX_SIZE_OFF    = 16'h9010;
  localparam logic [15:0] IRQ_STATUS_OFF = 16'h9014;
  localparam logic [15:0] IRQ_CLEAR_OFF  = 16'h9018;
  localparam logic [15:0] IRQ_ENABLE_OFF = 16'h901c;
  localparam logic [15:0] CONTROL_OFF    = 16'h9020;
  // reset values
  localparam logic [31:0] PTR_RESET      = 32'hffffffff;
  localparam logic [15:0] SIZE_RESET     = 16'h05ee;
  // field positions
  localparam int ADDR_BITS = 26;
  localparam int LEN_LSB   = 16;
  // event bits in status / enable / clear
  localparam int EV_TX_DONE  = 0;
  localparam int EV_RX_DONE  = 1;
  localparam int EV_TX_NULL  = 2;
  localparam int EV_RX_NULL  = 3;
  localparam int EV_RX_OVER  = 4;
  localparam int EV_RX_EARLY = 5;
  localparam int NUM_EV      = 6;
  // control bits
  localparam int CTL_TX_EN = 0;
  localparam int CTL_RX_EN = 1;
  localparam int CTL_TX_RS = 2;
  localparam int CTL_RX_RS = 3;
  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // frame-done report from a dma channel
  typedef struct packed {
    logic        done;
    logic [31:0] next_ptr;
  } frame_done_t;

  // receive-side length information from the mac
  typedef struct packed {
    logic        early;
    logic [15:0] length;
    logic        stored;
    logic [15:0] stored_bytes;
  } rx_info_t;
endpackage

// ==== rtl/event_status.sv ====
// sticky event status with enable mask and write-one-to-clear
module event_status #(
  parameter int N = 6
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [N-1:0] event_pulse,
  input  wire logic         clear_we,
  input  wire logic [N-1:0] clear_mask,
  input  wire logic [N-1:0] enable_reg,
  output logic      [N-1:0] status_reg,
  output logic              irq
);
  // set wins over clear so an event in the clearing cycle is kept
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          status_reg[i] <= 1'b0;
        end else if (event_pulse[i]) begin
          status_reg[i] <= 1'b1;
        end else if (clear_we && clear_mask[i]) begin
          status_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(status_reg & enable_reg);

  a_event_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
    (|event_pulse) |=> (status_reg & $past(event_pulse)) == $past(event_pulse))
    else $error("event lost in status");
endmodule

// ==== rtl/dma_pointers.sv ====
// The AXI4-Lite interface to the registers was left to the implementer.
module dma_pointers (
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  // axi4-lite slave
  input  wire logic [15:0]              s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [15:0]              s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // dma channel side
  input  wire dma_ptr_pkg::frame_done_t tx_done,
  input  wire dma_ptr_pkg::frame_done_t rx_done,
  input  wire dma_ptr_pkg::rx_info_t    rx_info,
  output logic [25:0]                   tx_desc_addr,
  output logic [25:0]                   rx_desc_addr,
  output logic                          tx_fetch_en,
  output logic                          rx_fetch_en,
  output logic                          tx_null_list_flag,
  output logic                          rx_oversize,
  output logic                          irq
);
  logic [31:0] tx_descriptor_pointer_reg;
  logic [31:0] rx_descriptor_pointer_reg;
  logic [15:0] rx_max_frame_size_reg;
  logic [15:0] rx_current_frame_length_reg;
  logic [3:0]  control_reg;
  logic [5:0]  irq_enable_reg;
  logic [5:0]  irq_status;
  logic [5:0]  event_pulse;
  logic        tx_null_prev_reg;
  logic        rx_null_prev_reg;
  logic        rx_oversize_next;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [15:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        wr_go;
  logic        wr_hit;
  logic        clear_we;
  logic [31:0] rdata_next;
  logic        rd_hit;
  logic        tx_null;
  logic        rx_null;

  // write channel capture: address and data may arrive in either order
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_go         = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 16'h0000;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // decode of the held write address; unmapped or read-only gets slverr
  always_comb begin
    wr_hit = 1'b1;
    unique case ({awaddr_reg[15:2], 2'b00})
      dma_ptr_pkg::TX_PTR_OFF,
      dma_ptr_pkg::RX_PTR_OFF,
      dma_ptr_pkg::RX_SIZE_OFF,
      dma_ptr_pkg::IRQ_CLEAR_OFF,
      dma_ptr_pkg::IRQ_ENABLE_OFF,
      dma_ptr_pkg::CONTROL_OFF: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // write response, held until the master takes it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dma_ptr_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? dma_ptr_pkg::RESP_OKAY
                             : dma_ptr_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic wr_at(input logic [15:0] off);
    return wr_go && ({awaddr_reg[15:2], 2'b00} == off);
  endfunction

  // tx pointer: software write, else advance after each frame while tx fetching is enabled
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_descriptor_pointer_reg <= dma_ptr_pkg::PTR_RESET;
    end else if (wr_at(dma_ptr_pkg::TX_PTR_OFF)) begin
      tx_descriptor_pointer_reg <= merge(tx_descriptor_pointer_reg,
                                         wdata_reg, wstrb_reg);
    end else if (tx_done.done && tx_fetch_en) begin
      tx_descriptor_pointer_reg <= tx_done.next_ptr;
    end
  end

  // rx pointer: same scheme as tx
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_descriptor_pointer_reg <= dma_ptr_pkg::PTR_RESET;
    end else if (wr_at(dma_ptr_pkg::RX_PTR_OFF)) begin
      rx_descriptor_pointer_reg <= merge(rx_descriptor_pointer_reg,
                                         wdata_reg, wstrb_reg);
    end else if (rx_done.done && rx_fetch_en) begin
      rx_descriptor_pointer_reg <= rx_done.next_ptr;
    end
  end

  // max frame size has no documented reset; a plain default keeps x out
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_max_frame_size_reg <= dma_ptr_pkg::SIZE_RESET;
    end else if (wr_at(dma_ptr_pkg::RX_SIZE_OFF)) begin
      if (wstrb_reg[0]) rx_max_frame_size_reg[7:0] <= wdata_reg[7:0];
      if (wstrb_reg[1]) rx_max_frame_size_reg[15:8] <= wdata_reg[15:8];
    end
  end

  // length latched on the early-notify event, read-only to software
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_current_frame_length_reg <= 16'h0000;
    end else if (rx_info.early) begin
      rx_current_frame_length_reg <= rx_info.length;
    end
  end

  // control and enable registers; reset bits self-clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      control_reg    <= 4'h0;
      irq_enable_reg <= 6'h00;
    end else begin
      control_reg[dma_ptr_pkg::CTL_TX_RS] <= 1'b0;
      control_reg[dma_ptr_pkg::CTL_RX_RS] <= 1'b0;
      if (wr_at(dma_ptr_pkg::CONTROL_OFF) && wstrb_reg[0]) begin
        control_reg <= wdata_reg[3:0];
      end
      if (wr_at(dma_ptr_pkg::IRQ_ENABLE_OFF) && wstrb_reg[0]) begin
        irq_enable_reg <= wdata_reg[5:0];
      end
    end
  end

  // null detection uses only the address bits
  assign tx_null      = tx_descriptor_pointer_reg[25:0] == 26'h0000000;
  assign rx_null      = rx_descriptor_pointer_reg[25:0] == 26'h0000000;
  assign tx_desc_addr = tx_descriptor_pointer_reg[25:0];
  assign rx_desc_addr = rx_descriptor_pointer_reg[25:0];
  // a null list stops new fetches; buffered data drains outside this block
  assign tx_fetch_en  = control_reg[dma_ptr_pkg::CTL_TX_EN] && !tx_null;
  assign rx_fetch_en  = control_reg[dma_ptr_pkg::CTL_RX_EN] && !rx_null;
  assign rx_oversize_next = rx_info.stored
                         && (rx_info.stored_bytes > rx_max_frame_size_reg);

  // null-list flag: set while pointer null with dma on, cleared by tx reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_null_list_flag <= 1'b0;
    end else if (tx_null && control_reg[dma_ptr_pkg::CTL_TX_EN]) begin
      tx_null_list_flag <= 1'b1;
    end else if (control_reg[dma_ptr_pkg::CTL_TX_RS]) begin
      tx_null_list_flag <= 1'b0;
    end
  end

  // edge memories and oversize flag
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_null_prev_reg <= 1'b0;
      rx_null_prev_reg <= 1'b0;
      rx_oversize      <= 1'b0;
    end else begin
      tx_null_prev_reg <= tx_null && control_reg[dma_ptr_pkg::CTL_TX_EN];
      rx_null_prev_reg <= rx_null && control_reg[dma_ptr_pkg::CTL_RX_EN];
      rx_oversize      <= rx_oversize_next;
    end
  end

  always_comb begin
    event_pulse = 6'h00;
    event_pulse[dma_ptr_pkg::EV_TX_DONE]  = tx_done.done && tx_fetch_en;
    event_pulse[dma_ptr_pkg::EV_RX_DONE]  = rx_done.done && rx_fetch_en;
    event_pulse[dma_ptr_pkg::EV_TX_NULL]  =
      tx_null && control_reg[dma_ptr_pkg::CTL_TX_EN] && !tx_null_prev_reg;
    event_pulse[dma_ptr_pkg::EV_RX_NULL]  =
      rx_null && control_reg[dma_ptr_pkg::CTL_RX_EN] && !rx_null_prev_reg;
    event_pulse[dma_ptr_pkg::EV_RX_OVER]  = rx_oversize_next;
    event_pulse[dma_ptr_pkg::EV_RX_EARLY] = rx_info.early;
  end

  assign clear_we = wr_at(dma_ptr_pkg::IRQ_CLEAR_OFF) && wstrb_reg[0];

  event_status #(.N(dma_ptr_pkg::NUM_EV)) u_events (
    .mclk        (mclk),
    .sys_rst     (sys_rst),
    .event_pulse (event_pulse),
    .clear_we    (clear_we),
    .clear_mask  (wdata_reg[5:0]),
    .enable_reg  (irq_enable_reg),
    .status_reg  (irq_status),
    .irq         (irq)
  );

  // read mux
  always_comb begin
    rd_hit     = 1'b1;
    rdata_next = 32'h00000000;
    unique case ({s_axi_araddr[15:2], 2'b00})
      dma_ptr_pkg::TX_PTR_OFF:     rdata_next = tx_descriptor_pointer_reg;
      dma_ptr_pkg::RX_PTR_OFF:     rdata_next = rx_descriptor_pointer_reg;
      dma_ptr_pkg::RX_SIZE_OFF:    rdata_next = {rx_current_frame_length_reg,
                                                 rx_max_frame_size_reg};
      dma_ptr_pkg::IRQ_STATUS_OFF: rdata_next = {26'h0, irq_status};
      dma_ptr_pkg::IRQ_CLEAR_OFF:  rdata_next = 32'h00000000;
      dma_ptr_pkg::IRQ_ENABLE_OFF: rdata_next = {26'h0, irq_enable_reg};
      dma_ptr_pkg::CONTROL_OFF:    rdata_next = {27'h0, tx_null_list_flag,
                                                 control_reg};
      default:                     rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  // read data registered, held until taken
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= dma_ptr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdata_next;
      s_axi_rresp  <= rd_hit ? dma_ptr_pkg::RESP_OKAY
                             : dma_ptr_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  a_tx_ptr_reset: assert property (@(posedge mclk)
    $past(sys_rst) |-> tx_descriptor_pointer_reg == dma_ptr_pkg::PTR_RESET)
    else $error("tx pointer not all ones after reset");
  a_tx_ptr_advance: assert property (@(posedge mclk)
    disable iff (sys_rst)
    (tx_done.done && tx_fetch_en
     && !wr_at(dma_ptr_pkg::TX_PTR_OFF))
    |=> tx_descriptor_pointer_reg == $past(tx_done.next_ptr))
    else $error("tx pointer did not advance");
  a_rx_ptr_reset: assert property (@(posedge mclk)
    $past(sys_rst) |-> rx_descriptor_pointer_reg == dma_ptr_pkg::PTR_RESET)
    else $error("rx pointer not all ones after reset");
  a_rx_ptr_advance: assert property (@(posedge mclk)
    disable iff (sys_rst)
    (rx_done.done && rx_fetch_en
     && !wr_at(dma_ptr_pkg::RX_PTR_OFF))
    |=> rx_descriptor_pointer_reg == $past(rx_done.next_ptr))
    else $error("rx pointer did not advance");
  a_oversize_flag: assert property (@(posedge mclk)
    disable iff (sys_rst)
    (rx_info.stored && rx_info.stored_bytes > rx_max_frame_size_reg)
    |=> rx_oversize && irq_status[dma_ptr_pkg::EV_RX_OVER])
    else $error("oversize not reported");
  a_length_latch: assert property (@(posedge mclk)
    disable iff (sys_rst)
    rx_info.early |=> rx_current_frame_length_reg == $past(rx_info.length)
                      && irq_status[dma_ptr_pkg::EV_RX_EARLY])
    else $error("frame length not latched on early notify");
  a_null_stops: assert property (@(posedge mclk)
    disable iff (sys_rst)
    (tx_descriptor_pointer_reg[25:0] == 26'h0) |-> !tx_fetch_en)
    else $error("tx fetch enabled with null pointer");
  a_null_flag_set: assert property (@(posedge mclk)
    disable iff (sys_rst)
    (tx_null && control_reg[dma_ptr_pkg::CTL_TX_EN]) |=> tx_null_list_flag)
    else $error("null list flag not set");
  a_addr_low_bits: assert property (@(posedge mclk)
    disable iff (sys_rst)
    (wr_at(dma_ptr_pkg::TX_PTR_OFF) && wstrb_reg == 4'hf)
    |=> tx_desc_addr == $past(wdata_reg[25:0]))
    else $error("tx address is not the low written pointer bits");
endmodule

// ==== test/far_side.sv ====
// behavioural channel and mac side: frame reports and receive length info
module far_side (
  input  wire logic                mclk,
  output dma_ptr_pkg::frame_done_t tx_done,
  output dma_ptr_pkg::frame_done_t rx_done,
  output dma_ptr_pkg::rx_info_t    rx_info
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle payloads start at zero, later carry the inverse of the last value, never stale data
  initial begin
    tx_done = '0;
    rx_done = '0;
    rx_info = '0;
  end

  // one frame handled on a channel, after gap idle cycles
  task automatic frame(input bit rx, input logic [31:0] p, input int gap);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    if (rx) rx_done <= '{1'b1, p};
    else tx_done <= '{1'b1, p};
    @(posedge mclk);
    if (rx) rx_done <= '{1'b0, ~p};
    else tx_done <= '{1'b0, ~p};
  endtask

  // length field seen (early) or frame stored, one cycle pulse each
  task automatic info(input bit st, input logic [15:0] n);
    @(posedge mclk);
    if (st) {rx_info.stored, rx_info.stored_bytes} <= {1'b1, n};
    else {rx_info.early, rx_info.length} <= {1'b1, n};
    @(posedge mclk);
    if (st) {rx_info.stored, rx_info.stored_bytes} <= {1'b0, ~n};
    else {rx_info.early, rx_info.length} <= {1'b0, ~n};
  endtask
endmodule

// ==== test/tb_buffered_dma_descriptor_pointers.sv ====
module tb_buffered_dma_descriptor_pointers;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     mclk, sys_rst, awvalid, wvalid, bready;
  logic                     arvalid, rready, awready, wready, bvalid;
  logic                     arready, rvalid, tx_fetch_en, rx_fetch_en;
  logic                     null_flag, rx_oversize, irq;
  logic [15:0]              awaddr, araddr, len;
  logic [31:0]              wdata, rdata, seed, v, w;
  logic [3:0]               wstrb;
  logic [1:0]               bresp, rresp;
  logic [25:0]              tx_addr, rx_addr;
  logic [33:0]              expq[$];
  dma_ptr_pkg::frame_done_t tx_done, rx_done;
  dma_ptr_pkg::rx_info_t    rx_info;
  int                       mismatches, checked, cycles, overs;

  dma_pointers DUT (.mclk(mclk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_done(tx_done),
    .rx_done(rx_done), .rx_info(rx_info), .tx_desc_addr(tx_addr),
    .rx_desc_addr(rx_addr), .tx_fetch_en(tx_fetch_en),
    .rx_fetch_en(rx_fetch_en), .tx_null_list_flag(null_flag),
    .rx_oversize(rx_oversize), .irq(irq));
  far_side u_far (.mclk(mclk), .tx_done(tx_done), .rx_done(rx_done),
    .rx_info(rx_info));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge mclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hf};
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er});
  endtask

  // read: expectation queued, the monitor compares when data returns
  task automatic rd(input logic [15:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    expq.push_back({er, d});
    @(posedge mclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  // result watcher, plus pulse counter and hang limit
  always @(posedge mclk) begin
    logic [33:0] e;
    if (rvalid && rready) begin
      e = expq.pop_front();
      check(rdata, e[31:0]);
      check({30'h0, rresp}, {30'h0, e[33:32]});
    end
    if (rx_oversize === 1'b1) overs++;
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    {sys_rst, awvalid, wvalid, bready, arvalid, rready} = 6'b100000;
    {awaddr, araddr, wdata, wstrb} = '0;
    {mismatches, checked, cycles, overs} = '0;
    seed = 32'hd017f75f;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(dma_ptr_pkg::TX_PTR_OFF, dma_ptr_pkg::PTR_RESET, 2'h0);
    rd(dma_ptr_pkg::RX_PTR_OFF, dma_ptr_pkg::PTR_RESET, 2'h0);
    rd(dma_ptr_pkg::RX_SIZE_OFF, {16'h0, dma_ptr_pkg::SIZE_RESET}, 2'h0);
    // software pointer writes, upper bits kept but unused for addressing
    for (int i = 0; i < 3; i++) begin
      v = rnd() | 32'h1;
      w = rnd() | 32'h1;
      wr(dma_ptr_pkg::TX_PTR_OFF, v, 2'h0);
      wr(dma_ptr_pkg::RX_PTR_OFF, w, 2'h0);
      rd(dma_ptr_pkg::TX_PTR_OFF, v, 2'h0);
      rd(dma_ptr_pkg::RX_PTR_OFF, w, 2'h0);
      check({6'h0, tx_addr}, {6'h0, v[25:0]});
      check({6'h0, rx_addr}, {6'h0, w[25:0]});
    end
    // channel advances: masked first, then raised and cleared
    wr(dma_ptr_pkg::CONTROL_OFF, 32'h3, 2'h0);
    for (int i = 0; i < 3; i++) begin
      v = rnd() | 32'h1;
      w = rnd() | 32'h1;
      wr(dma_ptr_pkg::IRQ_ENABLE_OFF, 32'h0, 2'h0);
      u_far.frame(1'b0, v, i);
      u_far.frame(1'b1, w, 2 - i);
      rd(dma_ptr_pkg::TX_PTR_OFF, v, 2'h0);
      rd(dma_ptr_pkg::RX_PTR_OFF, w, 2'h0);
      rd(dma_ptr_pkg::IRQ_STATUS_OFF, 32'h3, 2'h0);
      check({31'h0, irq}, 32'h0);
      wr(dma_ptr_pkg::IRQ_ENABLE_OFF, 32'h3f, 2'h0);
      check({31'h0, irq}, 32'h1);
      wr(dma_ptr_pkg::IRQ_CLEAR_OFF, 32'h3, 2'h0);
      check({31'h0, irq}, 32'h0);
    end
    // size limit: equal is accepted, one byte more is an error
    wr(dma_ptr_pkg::RX_SIZE_OFF, 32'h0064, 2'h0);
    rd(dma_ptr_pkg::RX_SIZE_OFF, 32'h0064, 2'h0);
    u_far.info(1'b1, 16'h0064);
    u_far.info(1'b1, 16'h0065);
    rd(dma_ptr_pkg::IRQ_STATUS_OFF, 32'h10, 2'h0);
    check(overs, 32'h1);
    // early notify: length readable, software places the next frame
    v = rnd();
    len = v[15:0];
    u_far.info(1'b0, len);
    rd(dma_ptr_pkg::RX_SIZE_OFF, {len, 16'h0064}, 2'h0);
    rd(dma_ptr_pkg::IRQ_STATUS_OFF, 32'h30, 2'h0);
    wr(dma_ptr_pkg::RX_PTR_OFF, w + len + 32'h40, 2'h0);
    rd(dma_ptr_pkg::RX_PTR_OFF, w + len + 32'h40, 2'h0);
    // null lists: flags up, fetching stops, reports ignored
    wr(dma_ptr_pkg::IRQ_CLEAR_OFF, 32'h3f, 2'h0);
    wr(dma_ptr_pkg::TX_PTR_OFF, 32'h0, 2'h0);
    wr(dma_ptr_pkg::RX_PTR_OFF, 32'h0, 2'h0);
    u_far.frame(1'b0, 32'h1234, 1);
    u_far.frame(1'b1, 32'h5678, 0);
    check({29'h0, null_flag, tx_fetch_en, rx_fetch_en}, 32'h4);
    rd(dma_ptr_pkg::TX_PTR_OFF, 32'h0, 2'h0);
    rd(dma_ptr_pkg::RX_PTR_OFF, 32'h0, 2'h0);
    rd(dma_ptr_pkg::IRQ_STATUS_OFF, 32'hc, 2'h0);
    rd(dma_ptr_pkg::CONTROL_OFF, 32'h13, 2'h0);
    // unmapped and read-only places refuse without effect
    rd(16'h9000, 32'h0, dma_ptr_pkg::RESP_SLVERR);
    wr(16'h9000, 32'h5, dma_ptr_pkg::RESP_SLVERR);
    wr(dma_ptr_pkg::IRQ_STATUS_OFF, 32'h0, dma_ptr_pkg::RESP_SLVERR);
    rd(dma_ptr_pkg::IRQ_STATUS_OFF, 32'hc, 2'h0);
    // new lists and both channel resets: null flag drops, fetching resumes
    wr(dma_ptr_pkg::TX_PTR_OFF, 32'h100, 2'h0);
    wr(dma_ptr_pkg::RX_PTR_OFF, 32'h200, 2'h0);
    wr(dma_ptr_pkg::CONTROL_OFF, 32'hf, 2'h0);
    rd(dma_ptr_pkg::CONTROL_OFF, 32'h3, 2'h0);
    check({30'h0, tx_fetch_en, rx_fetch_en}, 32'h3);
    repeat (3) @(posedge mclk);
    close_out();
  end
endmodule
